// ===== flash_pkg.sv
/*
 * shared constants for the serial flash page write and sector lock block:
 * opcodes, address layout, lock and status bit positions, cycle timing.
 * assumes a 125 MHz system clock; timing counts derive from that rate.
 */
package flash_pkg;

   // system clock rate and self-timed cycle length
   localparam int          CLK_MHZ        = 125;
   localparam int          PROG_TIME_NS   = 10000;
   localparam int          PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int          TIMER_W        = 11;
   localparam logic [10:0] PROG_COUNT     = 11'(PROG_CYCLES);

   // array layout, 2-Mbit variant
   localparam int          ADDR_W         = 18;
   localparam int          PAGE_W         = 10;
   localparam int          OFFS_W         = 8;
   localparam int          PAGE_BYTES     = 256;
   localparam int          STORE_BYTES    = 262144;
   localparam int          SECTORS        = 4;
   localparam int          SECTOR_MSB     = 17;
   localparam int          SECTOR_LSB     = 16;
   localparam int          BP_W           = 2;

   // opcodes
   localparam logic [7:0]  OP_WREN        = 8'h06;
   localparam logic [7:0]  OP_WRDI        = 8'h04;
   localparam logic [7:0]  OP_RDSR        = 8'h05;
   localparam logic [7:0]  OP_PAGE_WRITE  = 8'h0a;
   localparam logic [7:0]  OP_PAGE_PROG   = 8'h02;
   localparam logic [7:0]  OP_LOCK_WRITE  = 8'he5;
   localparam logic [7:0]  OP_LOCK_READ   = 8'he8;

   // frame byte counts: opcode plus three address bytes, then data
   localparam logic [2:0]  BYTES_CMD      = 3'h1;
   localparam logic [2:0]  BYTES_HDR      = 3'h4;
   localparam logic [2:0]  BYTES_LOCK     = 3'h5;
   localparam logic [2:0]  BYTES_SAT      = 3'h6;
   localparam logic [2:0]  PHASE_LAST     = 3'h7;

   // lock register and status bit positions
   localparam int          LOCK_WL_BIT    = 0;
   localparam int          LOCK_DN_BIT    = 1;
   localparam logic [5:0]  SPARE_ZERO     = 6'h00;

   // bp coverage codes
   localparam logic [1:0]  BP_TOP_QUARTER = 2'h1;
   localparam logic [1:0]  BP_TOP_HALF    = 2'h2;
   localparam logic [1:0]  BP_ALL         = 2'h3;
   localparam logic [1:0]  SECTOR_TOP     = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} cycle_state_t;

endpackage

// ===== page_store.sv
/*
 * byte-wide flash array, one write port, asynchronous read on the same address.
 * assumes the caller merges program data and serialises writes one byte a cycle.
 */
`timescale 1ns/1ps

module page_store (
   // clock
   input  wire logic                          clk,
   // byte port
   input  wire logic                          writeEn,
   input  wire logic [flash_pkg::ADDR_W-1:0]  byteAddr,
   input  wire logic [7:0]                    writeData,
   output logic      [7:0]                    readData
);
   import flash_pkg::*;

   // contents are not cleared; nonvolatile array starts as whatever it holds
   logic [7:0] cells [STORE_BYTES];

   // one byte per cycle write
   always_ff @(posedge clk) begin
      if (writeEn) begin
         cells[byteAddr] <= writeData;
      end
   end

   // read feeds the program merge in the same cycle
   assign readData = cells[byteAddr];

endmodule

// ===== serial_flash_page_write_lock.sv
/*
 * serial flash command engine for page write, page program and sector lock write,
 * with status and lock register readback on the serial output.
 * assumes sck stops between frames, and that select stays high for several
 * system clocks so the frame registers can be read while they hold still.
 */
`timescale 1ns/1ps

// Behaviour
// - lock-down set freezes sector lock bits
// - write-lock set blocks writes to sector
// - writes need write-enable latch set first
// - page write replaces supplied bytes, keeps others
// - data wraps within addressed page
// - last 256 bytes win; fewer disturb nothing
// - select must rise on byte boundary
// - valid write starts cycle, latch clears
// - status readable during cycle of fixed length
// - page write refused on any protected page
// - page program refused on hardware-protected page
// - writes refused while a cycle runs
// - page program only clears bits
// - lock write exactly four bytes plus data
// - lock write immediate, then latch clears
// - lock write refused while cycle runs
// - upper address bits ignored, 1..256 bytes
// - input bits taken on rising sck
// - lock read returns addressed sector byte
module serial_flash_page_write_lock (
   // system clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // serial link
   input  wire logic                        sck,
   input  wire logic                        selectN,
   input  wire logic                        serialInLine,
   output logic                             serialOutLine,
   output logic                             serialOutEnN,
   // protection state from the status register logic
   input  wire logic [flash_pkg::BP_W-1:0]  blockProtect,
   input  wire logic                        hwProtect,
   // status flags
   output logic                             writeLatchFlag,
   output logic                             cycleActiveFlag
);
   import flash_pkg::*;

   // link domain frame state, held after sck stops
   logic                inFrame_q;
   logic [2:0]          phase_q;
   logic [2:0]          byteNum_q;
   logic [7:0]          shift_q;
   logic [7:0]          cmd_q;
   logic [ADDR_W-1:0]   addr_q;
   logic [OFFS_W-1:0]   offset_q;
   logic                frameTog_q;
   logic [7:0]          bufMem [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] valid_q;
   logic [7:0]          outByte_q;
   logic                readAct_q;
   logic [1:0]          busyLink_q;
   logic [1:0]          welLink_q;
   logic [7:0]          lockLink0_q;
   logic [7:0]          lockLink_q;
   logic                serialOut_q;
   logic                serialOutEnN_q;

   // system domain state
   logic                rstLink_q;
   logic [1:0]          selSync_q;
   logic                selPrev_q;
   logic                decodeGo_q;
   logic [1:0]          togSync_q;
   logic                lastTog_q;
   cycle_state_t        state_q;
   cycle_state_t        state_d;
   logic [OFFS_W-1:0]   idx_q;
   logic [PAGE_W-1:0]   page_q;
   logic                ppMode_q;
   logic [TIMER_W-1:0]  timer_q;
   logic                busy_q;
   logic                wel_q;
   logic [SECTORS-1:0]  lockWl_q;
   logic [SECTORS-1:0]  lockDn_q;

   // link side decode: first edge of a frame restarts the byte framing
   logic [2:0]          phaseEff;
   logic [2:0]          byteEff;
   logic [7:0]          shiftNext;
   logic                byteDone;
   logic                cmdDone;
   logic                addrDone;
   logic                isWriteCmd;
   logic                dataDone;
   logic [1:0]          readSector;
   logic [7:0]          statusByte;
   logic [7:0]          lockReadByte;
   assign phaseEff     = inFrame_q ? phase_q : 3'h0;
   assign byteEff      = inFrame_q ? byteNum_q : 3'h0;
   assign shiftNext    = {shift_q[6:0], serialInLine};
   assign byteDone     = (phaseEff == PHASE_LAST);
   assign cmdDone      = byteDone && (byteEff == 3'h0);
   assign addrDone     = byteDone && (byteEff == (BYTES_HDR - 3'h1));
   assign isWriteCmd   = (cmd_q == OP_PAGE_WRITE) || (cmd_q == OP_PAGE_PROG);
   // buffer frozen while a cycle runs; partial bytes never reach it
   assign dataDone     = byteDone && (byteEff >= BYTES_HDR) && isWriteCmd
                         && !busyLink_q[1];
   assign readSector   = addr_q[SECTOR_MSB-8:SECTOR_LSB-8];
   assign statusByte   = {SPARE_ZERO, welLink_q[1], busyLink_q[1]};
   assign lockReadByte = {SPARE_ZERO, lockLink_q[SECTORS + 32'(readSector)],
                          lockLink_q[32'(readSector)]};

   // frame presence ends with select itself
   always_ff @(posedge sck or posedge selectN) begin
      if (selectN) inFrame_q <= 1'b0;
      else         inFrame_q <= 1'b1;
   end

   // one toggle per frame tells the system side a fresh frame was seen
   always_ff @(posedge sck or posedge rstLink_q) begin
      if (rstLink_q)       frameTog_q <= 1'b0;
      else if (!inFrame_q) frameTog_q <= ~frameTog_q;
   end

   // bit and byte framing, rising sck
   always_ff @(posedge sck) begin
      shift_q   <= shiftNext;
      phase_q   <= phaseEff + 3'h1;
      byteNum_q <= (byteDone && byteEff != BYTES_SAT) ? byteEff + 3'h1 : byteEff;
   end

   // opcode, address and page offset capture
   always_ff @(posedge sck) begin
      if (cmdDone) cmd_q <= shiftNext;
      if (byteDone && byteEff != 3'h0 && byteEff < BYTES_HDR) begin
         addr_q <= ADDR_W'({addr_q, shiftNext});
      end
      if (addrDone)      offset_q <= shiftNext;
      else if (dataDone) offset_q <= offset_q + 8'h01;
   end

   // page buffer: later bytes overwrite earlier ones at the wrapped offset
   always_ff @(posedge sck) begin
      if (cmdDone && !busyLink_q[1]) valid_q <= '0;
      else if (dataDone)             valid_q[offset_q] <= 1'b1;
      if (dataDone) bufMem[offset_q] <= shiftNext;
   end

   // readback byte for status and lock register reads
   always_ff @(posedge sck or posedge selectN) begin
      if (selectN) begin
         readAct_q <= 1'b0;
         outByte_q <= 8'h00;
      end else if (cmdDone && shiftNext == OP_RDSR) begin
         readAct_q <= 1'b1;
         outByte_q <= statusByte;
      end else if (byteDone && readAct_q && cmd_q == OP_RDSR) begin
         outByte_q <= statusByte;
      end else if (addrDone && cmd_q == OP_LOCK_READ && !busyLink_q[1]) begin
         readAct_q <= 1'b1;
         outByte_q <= lockReadByte;
      end
   end

   // output shifts on falling sck, released as soon as select rises
   always_ff @(negedge sck or posedge selectN) begin
      if (selectN) begin
         serialOut_q     <= 1'b0;
         serialOutEnN_q  <= 1'b1;
      end else begin
         serialOut_q     <= outByte_q[~phase_q];
         serialOutEnN_q  <= ~readAct_q;
      end
   end
   assign serialOutLine = serialOut_q;
   assign serialOutEnN  = serialOutEnN_q;

   // status and lock levels into the link domain; they only change slowly
   always_ff @(posedge sck) begin
      busyLink_q  <= {busyLink_q[0], busy_q};
      welLink_q   <= {welLink_q[0], wel_q};
      lockLink0_q <= {lockDn_q, lockWl_q};
      lockLink_q  <= lockLink0_q;
   end

   // select and frame toggle into the system domain; decode waits one more cycle
   always_ff @(posedge clk) begin
      rstLink_q <= rst;
      if (rst) begin
         selSync_q  <= 2'h3;
         selPrev_q  <= 1'b1;
         decodeGo_q <= 1'b0;
         togSync_q  <= 2'h0;
      end else begin
         selSync_q  <= {selSync_q[0], selectN};
         selPrev_q  <= selSync_q[1];
         decodeGo_q <= selSync_q[1] && !selPrev_q;
         togSync_q  <= {togSync_q[0], frameTog_q};
      end
   end

   // frame decode on select release; link registers are still at this point
   logic       newFrame;
   logic       wholeBytes;
   logic [1:0] sector;
   logic       covered;
   logic       isPW;
   logic       isPP;
   logic       idle;
   logic       writeGo;
   logic       lockGo;
   logic       wrenGo;
   logic       wrdiGo;
   assign newFrame   = decodeGo_q && (togSync_q[1] != lastTog_q);
   assign wholeBytes = (phase_q == 3'h0);
   assign sector     = addr_q[SECTOR_MSB:SECTOR_LSB];
   assign covered    = (blockProtect == BP_ALL)
                     || (blockProtect == BP_TOP_HALF && sector[1])
                     || (blockProtect == BP_TOP_QUARTER && sector == SECTOR_TOP);
   assign isPW       = (cmd_q == OP_PAGE_WRITE);
   assign isPP       = (cmd_q == OP_PAGE_PROG);
   assign idle       = (state_q == ST_IDLE);
   assign writeGo    = newFrame && idle && wholeBytes && (byteNum_q >= BYTES_LOCK)
                     && (isPW || isPP) && wel_q
                     && !lockWl_q[sector]
                     && !(isPW && covered)
                     && !(isPP && covered && hwProtect);
   assign lockGo     = newFrame && idle && wholeBytes && (byteNum_q == BYTES_LOCK)
                     && (cmd_q == OP_LOCK_WRITE) && wel_q
                     && !lockDn_q[sector];
   assign wrenGo     = newFrame && wholeBytes && (byteNum_q == BYTES_CMD)
                     && (cmd_q == OP_WREN);
   assign wrdiGo     = newFrame && wholeBytes && (byteNum_q == BYTES_CMD)
                     && (cmd_q == OP_WRDI);

   // cycle sequencer: walk the page, then hold out the cycle time
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (writeGo) state_d = ST_PROG;
         ST_PROG: if (idx_q == 8'hff) state_d = ST_WAIT;
         ST_WAIT: if (timer_q == '0) state_d = ST_IDLE;
         // the fourth code of the state vector is unused; fall back to idle
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q  <= (state_d != ST_IDLE);
      end
   end

   // page, mode, offset walk and cycle timer
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_q    <= 8'h00;
         page_q   <= '0;
         ppMode_q <= 1'b0;
         timer_q  <= '0;
      end else if (idle && writeGo) begin
         idx_q    <= 8'h00;
         page_q   <= addr_q[ADDR_W-1:OFFS_W];
         ppMode_q <= isPP;
         timer_q  <= PROG_COUNT - 11'h001;
      end else if (!idle) begin
         idx_q    <= idx_q + 8'h01;
         timer_q  <= timer_q - 11'h001;
      end
   end

   // array merge: page write replaces supplied bytes, program only clears bits
   logic [7:0]        memRd;
   logic [7:0]        memWr;
   logic              memWe;
   logic [ADDR_W-1:0] memAddr;
   assign memAddr = {page_q, idx_q};
   assign memWe   = (state_q == ST_PROG) && valid_q[idx_q];
   assign memWr   = ppMode_q ? (memRd & bufMem[idx_q]) : bufMem[idx_q];

   page_store store (
      .clk       (clk),
      .writeEn   (memWe),
      .byteAddr  (memAddr),
      .writeData (memWr),
      .readData  (memRd)
   );

   // write latch: cleared as the cycle starts or right after a lock write
   always_ff @(posedge clk) begin
      if (rst)                           wel_q <= 1'b0;
      else if (wrenGo && idle)           wel_q <= 1'b1;
      else if (wrdiGo || writeGo || lockGo) wel_q <= 1'b0;
   end

   // sector lock bits, cleared by reset (power-up), loaded from the data byte by a lock write to a sector not locked down
   always_ff @(posedge clk) begin
      if (rst) begin
         lockWl_q  <= '0;
         lockDn_q  <= '0;
         lastTog_q <= 1'b0;
      end else begin
         if (decodeGo_q) lastTog_q <= togSync_q[1];
         if (lockGo) begin
            lockWl_q[sector] <= shift_q[LOCK_WL_BIT];
            lockDn_q[sector] <= shift_q[LOCK_DN_BIT];
         end
      end
   end

   assign writeLatchFlag  = wel_q;
   assign cycleActiveFlag = busy_q;

   // cycle length counter for checking only
   logic [TIMER_W:0] busyCnt_q;
   always_ff @(posedge clk) begin
      if (rst || !busy_q) busyCnt_q <= '0;
      else                busyCnt_q <= busyCnt_q + 12'h001;
   end

   lockdown_hold_a: assert property (@(posedge clk) disable iff (rst)
      1 |=> (((lockWl_q ^ $past(lockWl_q)) | (lockDn_q ^ $past(lockDn_q)))
             & $past(lockDn_q)) == '0)
      else $error("locked-down sector bits changed");
   write_lock_a: assert property (@(posedge clk) disable iff (rst)
      $rose(busy_q) |-> !lockWl_q[page_q[PAGE_W-1:PAGE_W-2]])
      else $error("cycle started in write-locked sector");
   wel_needed_a: assert property (@(posedge clk) disable iff (rst)
      $rose(busy_q) |-> $past(wel_q) && !wel_q)
      else $error("cycle started without latch or latch not cleared");
   page_wrap_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_PROG) |=> (state_q != ST_PROG) || $stable(page_q))
      else $error("page changed during programming walk");
   cycle_len_a: assert property (@(posedge clk) disable iff (rst)
      $fell(busy_q) |-> (busyCnt_q == 12'(PROG_COUNT)))
      else $error("self-timed cycle has wrong length");
   prog_clear_a: assert property (@(posedge clk) disable iff (rst)
      (memWe && ppMode_q) |-> ((memWr & ~memRd) == 8'h00))
      else $error("page program set a bit");
   protect_a: assert property (@(posedge clk) disable iff (rst)
      writeGo |-> !(covered && (isPW || hwProtect)))
      else $error("write accepted on protected page");
   busy_reject_a: assert property (@(posedge clk) disable iff (rst)
      (busy_q && newFrame) |=> $stable(page_q) && $stable(lockWl_q) && $stable(lockDn_q))
      else $error("command acted during running cycle");
   lock_wel_a: assert property (@(posedge clk) disable iff (rst)
      lockGo |=> !wel_q && !busy_q)
      else $error("lock write did not clear latch at once");

   pw_done_c: cover property (@(posedge clk) disable iff (rst) $fell(busy_q) && !ppMode_q);
   pp_done_c: cover property (@(posedge clk) disable iff (rst) $fell(busy_q) && ppMode_q);
   lock_wr_c: cover property (@(posedge clk) disable iff (rst) lockGo);
   reject_c:  cover property (@(posedge clk) disable iff (rst) busy_q && newFrame);

endmodule

// ===== spi_host.sv
/*
 * serial host model: drives select, serial clock and input line for whole frames.
 * assumes the bench calls frame() one at a time; clock runs only inside frames.
 */
`timescale 1ns/1ps

module spi_host (
   // serial link toward the device
   output logic       sck,
   output logic       selectN,
   output logic       serialInLine,
   input  wire logic  serialOutLine,
   input  wire logic  serialOutEnN
);
   logic lastIn;
   logic lastEnN;
   // stays 0 only if the device drove the line on every read bit
   logic rdEnN;

   // idle link: deselected, clock parked low
   initial begin
      sck          = 1'b0;
      selectN      = 1'b1;
      serialInLine = 1'b0;
   end

   // one bit: data set while sck low, taken on the rising edge, 6 ns period
   task automatic bitOut(input logic v);
      serialInLine = v;
      #3 sck = 1'b1;
      lastIn = serialOutLine;
      lastEnN = serialOutEnN;
      #3 sck = 1'b0;
   endtask

   // whole bytes msb first, optional stray bits, optional byte read back
   task automatic frame(input logic [7:0] tx[$], input int stray, input bit doRd,
                        output logic [7:0] rd);
      int i;
      int b;
      rd = 8'h00;
      rdEnN = 1'b0;
      selectN = 1'b0; // select stays low for the whole sequence
      #3;
      for (i = 0; i < tx.size(); i++) begin
         for (b = 7; b >= 0; b--) bitOut(tx[i][b]); // msb first, high address first
      end
      for (b = 0; b < stray; b++) bitOut(1'b1);
      if (doRd) begin
         for (b = 7; b >= 0; b--) begin
            bitOut(1'b0);
            rd[b] = lastIn;
            rdEnN = rdEnN | lastEnN;
         end
      end
      #3 selectN = 1'b1; // raised right after the last bit sent, stray bits included
      serialInLine = ~serialInLine; // released line must not keep its last value
   endtask
endmodule

// ===== tb.sv
/*
 * self-checking bench: host frames for enable, page write/program, lock write/read.
 * assumes the host model and the design; memory contents are not visible at ports.
 */
`timescale 1ns/1ps

module tb;
   import flash_pkg::*;
   logic              clk, rst, sck, selectN, serialInLine, serialOutLine, serialOutEnN;
   logic [BP_W-1:0]   blockProtect;
   logic              hwProtect, writeLatchFlag, cycleActiveFlag;
   int                error_cnt, check_count, hiLen, hiStart, i;
   logic [7:0]        rd;
   logic [7:0]        q[$];

   // system clock, 8 ns
   initial clk = 1'b0;
   always #4 clk = ~clk;

   serial_flash_page_write_lock dut (.clk(clk), .rst(rst), .sck(sck), .selectN(selectN),
      .serialInLine(serialInLine), .serialOutLine(serialOutLine),
      .serialOutEnN(serialOutEnN), .blockProtect(blockProtect), .hwProtect(hwProtect),
      .writeLatchFlag(writeLatchFlag), .cycleActiveFlag(cycleActiveFlag));

   spi_host host (.sck(sck), .selectN(selectN), .serialInLine(serialInLine),
      .serialOutLine(serialOutLine), .serialOutEnN(serialOutEnN));

   // busy length counted where the flag is settled
   always @(negedge clk) if (cycleActiveFlag === 1'b1) hiLen++;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // deselect gap long enough for the decode to land
   task automatic send(input logic [7:0] tx[$], input int stray);
      host.frame(tx, stray, 1'b0, rd);
      repeat (12) @(negedge clk);
   endtask

   task automatic readBack(input logic [7:0] tx[$]);
      host.frame(tx, 0, 1'b1, rd);
      repeat (12) @(negedge clk);
   endtask

   task automatic lockIs(input logic [7:0] sec, input logic [7:0] exp);
      readBack('{OP_LOCK_READ, sec, 8'h00, 8'h00});
      check("lock byte", rd, exp);
      check("out enable", host.rdEnN, 0);
      check("out released", serialOutEnN, 1);
   endtask

   // bounded wait for the self-timed cycle to end
   task automatic waitIdle;
      int n;
      for (n = 0; n < 3000 && cycleActiveFlag !== 1'b0; n++) @(negedge clk);
      if (n == 3000) begin
         error_cnt++;
         complete_run();
      end
   endtask

   initial begin
      rst = 1'b1;
      blockProtect = '0;
      hwProtect = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check("latch", writeLatchFlag, 0);
      lockIs(8'h00, 8'h00);
      // refusals without the latch set and with stray bits
      send('{OP_PAGE_WRITE, 8'h00, 8'h01, 8'h00, 8'h5a}, 0);
      check("busy", cycleActiveFlag, 0);
      send('{OP_WREN}, 0);
      check("latch", writeLatchFlag, 1);
      readBack('{OP_RDSR});
      check("status", rd, 8'h02);
      send('{OP_WRDI}, 0);
      check("latch", writeLatchFlag, 0);
      send('{OP_WREN}, 0);
      send('{OP_PAGE_WRITE, 8'h00, 8'h01, 8'h00, 8'h5a}, 3);
      check("busy", cycleActiveFlag, 0);
      check("latch", writeLatchFlag, 1);
      $display("test enable done");
      // one byte, upper address bits set, then refused traffic during the cycle
      hiStart = hiLen;
      send('{OP_PAGE_WRITE, 8'hfc, 8'h02, 8'hf0, 8'ha5}, 0);
      check("busy", cycleActiveFlag, 1);
      check("latch", writeLatchFlag, 0);
      readBack('{OP_RDSR});
      check("status", rd, 8'h01);
      send('{OP_PAGE_PROG, 8'h00, 8'h03, 8'h00, 8'h00}, 0);
      send('{OP_LOCK_WRITE, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
      waitIdle();
      check("cycle length", hiLen - hiStart, PROG_COUNT);
      lockIs(8'h00, 8'h00);
      readBack('{OP_RDSR});
      check("status", rd, 8'h00);
      $display("test page write done");
      // sector lock bits
      send('{OP_WREN}, 0);
      send('{OP_LOCK_WRITE, 8'h01, 8'h00, 8'h00, 8'h01}, 0);
      check("latch", writeLatchFlag, 0);
      lockIs(8'h01, 8'h01);
      lockIs(8'h00, 8'h00);
      send('{OP_WREN}, 0);
      send('{OP_PAGE_WRITE, 8'h01, 8'h00, 8'h00, 8'h11}, 0);
      check("busy", cycleActiveFlag, 0);
      send('{OP_LOCK_WRITE, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01}, 0);
      lockIs(8'h02, 8'h00);
      send('{OP_LOCK_WRITE, 8'h01, 8'h00, 8'h00, 8'h03}, 0);
      lockIs(8'h01, 8'h03);
      send('{OP_WREN}, 0);
      send('{OP_LOCK_WRITE, 8'h01, 8'h00, 8'h00, 8'h00}, 0);
      lockIs(8'h01, 8'h03);
      $display("test lock done");
      // protection map, then an over-long page write
      // known byte under the later program merge, else it reads unknown
      send('{OP_PAGE_WRITE, 8'h03, 8'h00, 8'h00, 8'hf3}, 0);
      check("busy", cycleActiveFlag, 1);
      waitIdle();
      send('{OP_WREN}, 0);
      blockProtect = BP_TOP_QUARTER;
      send('{OP_PAGE_WRITE, 8'h03, 8'h00, 8'h00, 8'h22}, 0);
      check("busy", cycleActiveFlag, 0);
      send('{OP_PAGE_PROG, 8'h03, 8'h00, 8'h00, 8'h22}, 0);
      check("busy", cycleActiveFlag, 1);
      waitIdle();
      send('{OP_WREN}, 0);
      hwProtect = 1'b1;
      send('{OP_PAGE_PROG, 8'h03, 8'h00, 8'h00, 8'h22}, 0);
      check("busy", cycleActiveFlag, 0);
      q = '{OP_PAGE_WRITE, 8'h02, 8'h00, 8'h80};
      for (i = 0; i < 260; i++) q.push_back(i[7:0]);
      send(q, 0);
      check("busy", cycleActiveFlag, 1);
      waitIdle();
      blockProtect = '0;
      hwProtect = 1'b0;
      $display("test protect done");
      // power-up clears frozen lock bits
      @(negedge clk);
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      lockIs(8'h01, 8'h00);
      $display("test power-up done");
      complete_run();
   end
endmodule
